// File: scb_map.svh
// Register offsets, field positions and timing counts for clock bring-up.
`ifndef SCB_MAP_SVH
`define SCB_MAP_SVH
`define SCB_REG_VARIANT       9'h002
`define SCB_REG_PLL_RST       9'h008
`define SCB_REG_CLKGEN_RST    9'h009
`define SCB_REG_PLL_EN        9'h010
`define SCB_REG_PLL_CFG       9'h011
`define SCB_REG_CLK_IN        9'h014
`define SCB_REG_LOCK_A        9'h01a
`define SCB_REG_LOCK_B        9'h01b
`define SCB_REG_CLK_MGMT      9'h020
`define SCB_REG_LOGIC_EN      9'h022
`define SCB_REG_LOCK_STAT     9'h018
`define SCB_REG_IMG_CORE      9'h029
`define SCB_REG_BIAS_CP       9'h041
`define SCB_REG_BIAS_FE       9'h042
`define SCB_REG_BIAS_MUX      9'h043
`define SCB_REG_BIAS_SER      9'h044
`define SCB_REG_RSV_A         9'h046
`define SCB_REG_RSV_B         9'h051
`define SCB_REG_BLACK         9'h080
`define SCB_REG_OUT_WIDTH     9'h081
`define SCB_REG_EXP_A         9'h0b0
`define SCB_REG_EXP_B         9'h0b4
`define SCB_REG_EXP_C         9'h0b5
`define SCB_REG_SEQ_A         9'h0da
`define SCB_REG_SEQ_B         9'h0e0
`define SCB_REG_SEQ_D         9'h1bf
`define SCB_REG_SEQ_E         9'h1c0
`define SCB_REG_SEQ_C         9'h1c8
`define SCB_OUT_WIDTH_BIT     13
`define SCB_PLL_EN_BIT        0
`define SCB_PLL_BYPASS_BIT    2
`define SCB_CLK_IN_LVDS_BIT   0
`define SCB_CLK_LOGIC_BIT     1
`define SCB_LOGIC_EN_BIT      0
`define SCB_LOCK_CYCLES       16
`define SCB_NREGS             27
`define SCB_NSTEPS            40
`define SCB_APB_CTRL          12'h000
`define SCB_APB_STATUS        12'h004
`define SCB_CTRL_START_BIT    0
`define SCB_CTRL_COLOUR_BIT   1
`define SCB_CTRL_MODE_LSB     2
`endif

// File: scb_pkg.sv
// Types shared by the bring-up controller and the testbench.
package scb_pkg;
	typedef enum logic [2:0] {
		SCB_M8_PLL   = 3'b000,
		SCB_M8_LVDS  = 3'b001,
		SCB_M10_PLL  = 3'b010,
		SCB_M10_LVDS = 3'b011,
		SCB_MPAR     = 3'b100
	} scb_mode_t;
	typedef struct packed {
		logic [8:0]  addr;
		logic [15:0] data;
	} scb_step_t;
endpackage

// File: scb_if.sv
// Register access link between the bring-up controller and the sensor clock block.
`timescale 1ns/100ps
`default_nettype none
interface scb_if;
	logic        req;
	logic        wr;
	logic [8:0]  addr;
	logic [15:0] wdata;
	logic        ack;
	logic [15:0] rdata;
	modport device (input req, wr, addr, wdata, output ack, rdata);
	modport host (output req, wr, addr, wdata, input ack, rdata);
endinterface
`default_nettype wire

// File: scb_lock_det.sv
// PLL lock detector: counts stable cycles of the PLL running indication.
`timescale 1ns/100ps
`include "scb_map.svh"
`default_nettype none
module scb_lock_det #(
	parameter int CYCLES = `SCB_LOCK_CYCLES
) (
	// Clock and reset
	input  wire logic clk,
	input  wire logic resetn,
	// PLL state
	input  wire logic pll_running,
	// Lock flag
	output logic      locked
);
	logic [15:0] cnt_r;
	logic [15:0] cnt_nxt;
	logic        locked_r;
	logic        locked_nxt;

	always_comb begin
		cnt_nxt = cnt_r;
		locked_nxt = locked_r;
		if (!pll_running) begin
			cnt_nxt = 16'h0000;
			locked_nxt = 1'b0;
		end else if (cnt_r == 16'(CYCLES - 1)) begin
			locked_nxt = 1'b1;
		end else begin
			cnt_nxt = cnt_r + 16'h0001;
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			cnt_r <= 16'h0000;
			locked_r <= 1'b0;
		end else begin
			cnt_r <= cnt_nxt;
			locked_r <= locked_nxt;
		end
	end

	assign locked = locked_r;
endmodule
`default_nettype wire

// File: scb_device.sv
// Sensor clock-management register file with PLL start, lock detect and clock enables.
`timescale 1ns/100ps
`include "scb_map.svh"
`default_nettype none
module scb_device (
	// Clock and reset
	input  wire logic clk,
	input  wire logic resetn,
	// Register link
	scb_if.device     bus,
	// Clock and output-width status outputs
	output logic      pll_running,
	output logic      pll_bypass,
	output logic      lvds_clk_sel,
	output logic      logic_clk_on,
	output logic      logic_blocks_on,
	output logic      width_8bit
);
	localparam int N = `SCB_NREGS;
	localparam logic [8:0] ADDRS [N] = '{
		`SCB_REG_VARIANT, `SCB_REG_PLL_RST, `SCB_REG_CLKGEN_RST, `SCB_REG_PLL_EN,
		`SCB_REG_PLL_CFG, `SCB_REG_CLK_IN, `SCB_REG_LOCK_A, `SCB_REG_LOCK_B,
		`SCB_REG_CLK_MGMT, `SCB_REG_LOGIC_EN, `SCB_REG_IMG_CORE, `SCB_REG_BIAS_CP,
		`SCB_REG_BIAS_FE, `SCB_REG_BIAS_MUX, `SCB_REG_BIAS_SER, `SCB_REG_RSV_A,
		`SCB_REG_RSV_B, `SCB_REG_BLACK, `SCB_REG_OUT_WIDTH, `SCB_REG_EXP_A,
		`SCB_REG_EXP_B, `SCB_REG_EXP_C, `SCB_REG_SEQ_A, `SCB_REG_SEQ_B,
		`SCB_REG_SEQ_D, `SCB_REG_SEQ_E, `SCB_REG_SEQ_C};
	// Soft-reset registers come up asserted; everything else at zero.
	localparam int I_PLL_RST = 1;
	localparam int I_CLKGEN_RST = 2;
	localparam int I_PLL_EN = 3;
	localparam int I_CLK_IN = 5;
	localparam int I_CLK_MGMT = 8;
	localparam int I_LOGIC_EN = 9;
	localparam int I_WIDTH = 18;

	logic [15:0] regs_r   [N];
	logic [15:0] regs_nxt [N];
	logic        ack_r;
	logic        ack_nxt;
	logic [15:0] rdata_r;
	logic [15:0] rdata_nxt;
	logic        locked;
	logic        pll_go;

	// The PLL runs only once its soft reset is released and the enable word
	// is written, which is the last step of the configuration group.
	assign pll_go = (regs_r[I_PLL_RST] == 16'h0000)
		&& regs_r[I_PLL_EN][`SCB_PLL_EN_BIT] && !regs_r[I_PLL_EN][`SCB_PLL_BYPASS_BIT];

	scb_lock_det #(
		.CYCLES(`SCB_LOCK_CYCLES)
	) u_lock (
		.clk        (clk),
		.resetn     (resetn),
		.pll_running(pll_go),
		.locked     (locked)
	);

	always_comb begin
		for (int i = 0; i < N; i++) begin
			regs_nxt[i] = regs_r[i];
		end
		ack_nxt = 1'b0;
		rdata_nxt = rdata_r;
		// One access per request; ack drops between accesses.
		if (bus.req && !ack_r) begin
			ack_nxt = 1'b1;
			rdata_nxt = 16'h0000;
			if (!bus.wr && bus.addr == `SCB_REG_LOCK_STAT) begin
				rdata_nxt = {15'h0000, locked};
			end
			for (int i = 0; i < N; i++) begin
				if (bus.addr == ADDRS[i]) begin
					if (bus.wr) begin
						regs_nxt[i] = bus.wdata;
					end else begin
						rdata_nxt = regs_r[i];
					end
				end
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			for (int i = 0; i < N; i++) begin
				regs_r[i] <= 16'h0000;
			end
			regs_r[I_PLL_RST] <= 16'h0001;
			regs_r[I_CLKGEN_RST] <= 16'h0001;
			ack_r <= 1'b0;
			rdata_r <= 16'h0000;
		end else begin
			for (int i = 0; i < N; i++) begin
				regs_r[i] <= regs_nxt[i];
			end
			ack_r <= ack_nxt;
			rdata_r <= rdata_nxt;
		end
	end

	assign bus.ack = ack_r;
	assign bus.rdata = rdata_r;
	assign pll_running = pll_go;
	assign pll_bypass = regs_r[I_PLL_EN][`SCB_PLL_BYPASS_BIT];
	assign lvds_clk_sel = regs_r[I_CLK_IN][`SCB_CLK_IN_LVDS_BIT];
	// Logic clock needs the clock generator out of reset and a live source.
	assign logic_clk_on = (regs_r[I_CLKGEN_RST] == 16'h0000)
		&& regs_r[I_CLK_MGMT][`SCB_CLK_LOGIC_BIT]
		&& (locked || lvds_clk_sel || pll_bypass);
	assign logic_blocks_on = logic_clk_on && regs_r[I_LOGIC_EN][`SCB_LOGIC_EN_BIT];
	assign width_8bit = regs_r[I_WIDTH][`SCB_OUT_WIDTH_BIT];
endmodule
`default_nettype wire

// File: scb_host.sv
// Bring-up controller: APB slave that plays the clock-management upload sequence.
//
// The APB slave port was left to the implementer.
`timescale 1ns/100ps
`include "scb_map.svh"
`default_nettype none
module scb_host (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        resetn,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	// Register link
	scb_if.host              bus
);
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000, ST_WR = 3'b001, ST_POLL = 3'b010,
		ST_WAIT = 3'b011, ST_DONE = 3'b100
	} scb_st_t;
	localparam int NS = `SCB_NSTEPS;

	scb_st_t          st_r, st_nxt;
	logic [5:0]       idx_r, idx_nxt;
	scb_pkg::scb_mode_t mode_r, mode_nxt;
	logic             colour_r, colour_nxt;
	logic             req_r, req_nxt;
	logic             wr_r, wr_nxt;
	logic [8:0]       addr_r, addr_nxt;
	logic [15:0]      wdata_r, wdata_nxt;
	logic [31:0]      prdata_r, prdata_nxt;
	scb_pkg::scb_step_t step;
	logic             pll_mode;

	assign pll_mode = (mode_r == scb_pkg::SCB_M8_PLL) || (mode_r == scb_pkg::SCB_M10_PLL);

	// Step table; index 3 onward of group one is mode specific.
	function automatic scb_pkg::scb_step_t step_of(input logic [5:0] i,
		input scb_pkg::scb_mode_t m, input logic c);
		logic p8;
		logic p10;
		logic par;
		p8 = (m == scb_pkg::SCB_M8_PLL);
		p10 = (m == scb_pkg::SCB_M10_PLL);
		par = (m == scb_pkg::SCB_MPAR);
		step_of = '{`SCB_REG_VARIANT, {14'h0000, par, c}};
		unique case (i)
			6'd0: step_of = '{`SCB_REG_VARIANT, {14'h0000, par, c}};
			6'd1: step_of = '{`SCB_REG_CLK_MGMT, p8 || par ? 16'h200C : p10 ? 16'h2004
				: m == scb_pkg::SCB_M8_LVDS ? 16'h2008 : 16'h2000};
			6'd2: step_of = '{`SCB_REG_CLK_IN, p8 || p10 || par ? 16'h0000 : 16'h0001};
			6'd3: step_of = '{`SCB_REG_PLL_EN, 16'h0007};
			6'd4: step_of = '{`SCB_REG_PLL_CFG, p8 ? 16'h210F : 16'h2113};
			6'd5: step_of = '{`SCB_REG_LOCK_A, p8 ? 16'h1180 : 16'h2280};
			6'd6: step_of = '{`SCB_REG_LOCK_B, p8 ? 16'hCCBC : 16'h3D2D};
			6'd7: step_of = '{`SCB_REG_PLL_RST, 16'h0000};
			6'd8: step_of = '{`SCB_REG_PLL_EN, 16'h0003};
			6'd9: step_of = '{`SCB_REG_CLKGEN_RST, 16'h0000};
			6'd10: step_of = '{`SCB_REG_CLK_MGMT, p8 || par ? 16'h200E
				: m == scb_pkg::SCB_M8_LVDS ? 16'h200A : p10 ? 16'h2006 : 16'h2002};
			6'd11: step_of = '{`SCB_REG_LOGIC_EN, 16'h0001};
			6'd12: step_of = '{`SCB_REG_IMG_CORE, 16'h085A};
			6'd13: step_of = '{`SCB_REG_OUT_WIDTH, (p8 || m == scb_pkg::SCB_M8_LVDS)
				? 16'h2000 : 16'h0000};
			6'd14: step_of = '{`SCB_REG_BIAS_CP, 16'h288B};
			6'd15: step_of = '{`SCB_REG_BIAS_FE, 16'h53C6};
			6'd16: step_of = '{`SCB_REG_BIAS_MUX, 16'h0344};
			6'd17: step_of = '{`SCB_REG_BIAS_SER, 16'h0085};
			6'd18: step_of = '{`SCB_REG_RSV_A, 16'h4888};
			6'd19: step_of = '{`SCB_REG_RSV_B, 16'h86A1};
			6'd20: step_of = '{`SCB_REG_BLACK, 16'h460F};
			6'd21: step_of = '{`SCB_REG_EXP_A, 16'h00F5};
			6'd22: step_of = '{`SCB_REG_EXP_B, 16'h00FD};
			6'd23: step_of = '{`SCB_REG_EXP_C, 16'h0144};
			6'd24: step_of = '{`SCB_REG_SEQ_A, 16'h160B};
			6'd25: step_of = '{`SCB_REG_SEQ_B, 16'h3E13};
			6'd26: step_of = '{`SCB_REG_SEQ_C, 16'h0386};
			6'd27: step_of = '{`SCB_REG_SEQ_D, 16'h0BF1};
			6'd28: step_of = '{`SCB_REG_SEQ_E, 16'h0BC3};
			default: step_of = '{`SCB_REG_VARIANT, {14'h0000, par, c}};
		endcase
	endfunction

	assign step = step_of(idx_r, mode_r, colour_r);

	always_comb begin
		st_nxt = st_r;
		idx_nxt = idx_r;
		mode_nxt = mode_r;
		colour_nxt = colour_r;
		req_nxt = req_r;
		wr_nxt = wr_r;
		addr_nxt = addr_r;
		wdata_nxt = wdata_r;
		prdata_nxt = 32'h0000_0000;
		if (psel && !penable && !pwrite && paddr == `SCB_APB_STATUS) begin
			prdata_nxt = {29'h0000_0000, st_r == ST_POLL, st_r == ST_DONE, st_r != ST_IDLE};
		end
		if (psel && !penable && !pwrite && paddr == `SCB_APB_CTRL) begin
			prdata_nxt = {27'h000_0000, mode_r, colour_r, 1'b0};
		end
		unique case (st_r)
			ST_IDLE, ST_DONE: begin
				if (psel && penable && pwrite && paddr == `SCB_APB_CTRL
					&& pwdata[`SCB_CTRL_START_BIT]) begin
					mode_nxt = scb_pkg::scb_mode_t'(pwdata[`SCB_CTRL_MODE_LSB +: 3]);
					colour_nxt = pwdata[`SCB_CTRL_COLOUR_BIT];
					idx_nxt = 6'd0;
					st_nxt = ST_WR;
				end
			end
			ST_WR: begin
				// One complete write before the next step is issued.
				if (!req_r) begin
					req_nxt = 1'b1;
					wr_nxt = 1'b1;
					addr_nxt = step.addr;
					wdata_nxt = step.data;
				end else if (bus.ack) begin
					req_nxt = 1'b0;
					st_nxt = ST_WR;
					unique case (idx_r)
						6'd2: idx_nxt = pll_mode ? 6'd4
							: (mode_r == scb_pkg::SCB_MPAR) ? 6'd3 : 6'd9;
						6'd3: idx_nxt = 6'd9;
						6'd8: st_nxt = ST_POLL;
						6'd28: st_nxt = ST_DONE;
						default: idx_nxt = idx_r + 6'd1;
					endcase
				end
			end
			ST_POLL: begin
				req_nxt = 1'b1;
				wr_nxt = 1'b0;
				addr_nxt = `SCB_REG_LOCK_STAT;
				st_nxt = ST_WAIT;
			end
			ST_WAIT: begin
				if (bus.ack) begin
					req_nxt = 1'b0;
					st_nxt = bus.rdata[0] ? ST_WR : ST_POLL;
					idx_nxt = bus.rdata[0] ? 6'd9 : idx_r;
				end
			end
			default: st_nxt = ST_IDLE;
		endcase
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			st_r <= ST_IDLE;
			idx_r <= 6'd0;
			mode_r <= scb_pkg::SCB_M8_PLL;
			colour_r <= 1'b0;
			req_r <= 1'b0;
			wr_r <= 1'b0;
			addr_r <= 9'h000;
			wdata_r <= 16'h0000;
			prdata_r <= 32'h0000_0000;
		end else begin
			st_r <= st_nxt;
			idx_r <= idx_nxt;
			mode_r <= mode_nxt;
			colour_r <= colour_nxt;
			req_r <= req_nxt;
			wr_r <= wr_nxt;
			addr_r <= addr_nxt;
			wdata_r <= wdata_nxt;
			prdata_r <= prdata_nxt;
		end
	end

	assign pready = psel && penable;
	assign pslverr = 1'b0;
	assign prdata = prdata_r;
	assign bus.req = req_r;
	assign bus.wr = wr_r;
	assign bus.addr = addr_r;
	assign bus.wdata = wdata_r;
endmodule
`default_nettype wire

// File: scb_props.sv
// Concurrent checks on the register link between the bring-up controller and the clock block.
`timescale 1ns/100ps
`include "scb_map.svh"
`default_nettype none
module scb_props (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        resetn,
	// Register link
	input  wire logic        req,
	input  wire logic        wr,
	input  wire logic [8:0]  addr,
	input  wire logic [15:0] wdata,
	input  wire logic        ack,
	input  wire logic [15:0] rdata
);
	localparam int LK = `SCB_LOCK_CYCLES;
	logic       wr_ack;
	logic       rd_lock;
	logic [5:0] cnt_r;
	logic [5:0] cnt_nxt;
	logic       pll_on_r;
	logic       pll_on_nxt;
	logic       rel_r;
	logic       rel_nxt;
	logic       seen_r;
	logic       seen_nxt;
	logic       byp_r;
	logic       byp_nxt;
	assign wr_ack = ack && wr;
	assign rd_lock = ack && !wr && addr == `SCB_REG_LOCK_STAT;
	// Tracks what the link has carried so far since reset.
	always_comb begin
		cnt_nxt = (pll_on_r && cnt_r != 6'h3f) ? cnt_r + 6'h01 : cnt_r;
		pll_on_nxt = pll_on_r;
		rel_nxt = rel_r || (wr_ack && addr == `SCB_REG_PLL_RST && wdata == 16'h0000);
		seen_nxt = seen_r || (rd_lock && rdata[0]);
		byp_nxt = byp_r || (wr_ack && addr == `SCB_REG_PLL_EN && wdata == 16'h0007);
		if (wr_ack && addr == `SCB_REG_PLL_EN && wdata == 16'h0003) begin
			pll_on_nxt = 1'b1;
			cnt_nxt = 6'h00;
		end
	end
	always_ff @(posedge clk) begin
		if (!resetn) begin
			cnt_r <= 6'h00;
			pll_on_r <= 1'b0;
			rel_r <= 1'b0;
			seen_r <= 1'b0;
			byp_r <= 1'b0;
		end else begin
			cnt_r <= cnt_nxt;
			pll_on_r <= pll_on_nxt;
			rel_r <= rel_nxt;
			seen_r <= seen_nxt;
			byp_r <= byp_nxt;
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);
	a_ack_follows_req: assert property (req && !ack |=> ack)
		else $error("link request not answered in one cycle");
	a_ack_single: assert property (ack |=> !ack)
		else $error("link answer longer than one cycle");
	a_ack_needs_req: assert property (ack |-> $past(req))
		else $error("link answer without request");
	a_req_held: assert property (req && !ack |=> req && $stable(addr) && $stable(wr) && $stable(wdata))
		else $error("link request changed before answer");
	a_req_released: assert property (ack |=> !req)
		else $error("link request not released after answer");
	a_lock_late: assert property (rd_lock && rdata[0] |-> pll_on_r && cnt_r >= LK - 2)
		else $error("lock flag set too early");
	a_pll_after_release: assert property (wr_ack && addr == `SCB_REG_PLL_EN && wdata == 16'h0003 |-> rel_r)
		else $error("PLL enabled before its reset release");
	a_group2_after_lock: assert property (wr_ack && addr == `SCB_REG_CLKGEN_RST && pll_on_r |-> seen_r)
		else $error("second group started before lock");
	a_par_no_poll: assert property (rd_lock |-> !byp_r)
		else $error("lock flag read in parallel variant");
	c_lock_seen: cover property (rd_lock && rdata[0]);
	c_bypass: cover property (wr_ack && addr == `SCB_REG_PLL_EN && wdata == 16'h0007);
	c_blocks_on: cover property (wr_ack && addr == `SCB_REG_LOGIC_EN);
endmodule
`default_nettype wire

// File: scb_tb.sv
// Self-checking bench: plays every bring-up mode through APB and checks the link and clocks.
`timescale 1ns/100ps
`include "scb_map.svh"
`default_nettype none
module tb;
	logic        clk = 1'b0;
	logic        resetn = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	wire logic [5:0] outs;
	int          failures = 0;
	int          checked = 0;
	int          lock_reads;
	scb_pkg::scb_step_t log_q[$];
	scb_pkg::scb_step_t exp_q[$];
	scb_if link ();
	scb_host scb_host_inst (.clk(clk), .resetn(resetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .bus(link));
	scb_device scb_device_inst (.clk(clk), .resetn(resetn), .bus(link),
		.pll_running(outs[5]), .pll_bypass(outs[4]), .lvds_clk_sel(outs[3]),
		.logic_clk_on(outs[2]), .logic_blocks_on(outs[1]), .width_8bit(outs[0]));
	scb_props scb_props_inst (.clk(clk), .resetn(resetn), .req(link.req), .wr(link.wr),
		.addr(link.addr), .wdata(link.wdata), .ack(link.ack), .rdata(link.rdata));
	always #25 clk = ~clk;
	// Records every completed link write and every lock-flag read.
	always @(posedge clk) begin
		if (link.req === 1'b1 && link.ack === 1'b1) begin
			if (link.wr === 1'b1)
				log_q.push_back({link.addr, link.wdata});
			else if (link.addr === `SCB_REG_LOCK_STAT)
				lock_reads++;
		end
	end
	task automatic end_of_test();
		$display("failures=%0d checked=%0d", failures, checked);
		if (failures == 0 && checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			failures++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// One APB transfer; called just after a rising edge.
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
			output logic [31:0] q);
		int n;
		n = 0;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		q = prdata;
		chk(pslverr, 1'b0);
		psel <= 1'b0;
		penable <= 1'b0;
		// One idle edge keeps back-to-back calls from driving psel twice at once.
		@(posedge clk);
		if (n >= 50) begin
			failures++;
			end_of_test();
		end
	endtask
	task automatic push(input logic [8:0] a, input logic [15:0] d);
		exp_q.push_back({a, d});
	endtask
	task automatic run_mode(input scb_pkg::scb_mode_t m, input logic c);
		logic [31:0] q;
		logic        pll;
		logic        b8;
		int          n;
		pll = (m == scb_pkg::SCB_M8_PLL || m == scb_pkg::SCB_M10_PLL);
		b8 = (m == scb_pkg::SCB_M8_PLL || m == scb_pkg::SCB_M8_LVDS);
		resetn <= 1'b0;
		repeat (4) @(posedge clk);
		resetn <= 1'b1;
		@(posedge clk);
		log_q.delete();
		exp_q.delete();
		lock_reads = 0;
		apb(1'b1, `SCB_APB_CTRL, {27'h0, m, c, 1'b1}, q);
		n = 0;
		do begin
			apb(1'b0, `SCB_APB_STATUS, 32'h0000_0000, q);
			n++;
		end while (q[1] !== 1'b1 && n < 2000);
		chk(q[1], 1'b1);
		if (n >= 2000) end_of_test();
		apb(1'b0, `SCB_APB_CTRL, 32'h0000_0000, q);
		chk(q, {27'h0, m, c, 1'b0});
		apb(1'b0, 12'h008, 32'h0000_0000, q);
		chk(q, 32'h0000_0000);
		push(`SCB_REG_VARIANT, {14'h0, m == scb_pkg::SCB_MPAR, c});
		if (pll) begin
			push(`SCB_REG_CLK_MGMT, b8 ? 16'h200c : 16'h2004);
			push(`SCB_REG_CLK_IN, 16'h0000);
			push(`SCB_REG_PLL_CFG, b8 ? 16'h210f : 16'h2113);
			push(`SCB_REG_LOCK_A, b8 ? 16'h1180 : 16'h2280);
			push(`SCB_REG_LOCK_B, b8 ? 16'hccbc : 16'h3d2d);
			push(`SCB_REG_PLL_RST, 16'h0000);
			push(`SCB_REG_PLL_EN, 16'h0003);
		end else if (m == scb_pkg::SCB_MPAR) begin
			push(`SCB_REG_CLK_MGMT, 16'h200c);
			push(`SCB_REG_CLK_IN, 16'h0000);
			push(`SCB_REG_PLL_EN, 16'h0007);
		end else begin
			push(`SCB_REG_CLK_MGMT, b8 ? 16'h2008 : 16'h2000);
			push(`SCB_REG_CLK_IN, 16'h0001);
		end
		push(`SCB_REG_CLKGEN_RST, 16'h0000);
		push(`SCB_REG_CLK_MGMT, (m == scb_pkg::SCB_M8_PLL || m == scb_pkg::SCB_MPAR) ? 16'h200e :
			m == scb_pkg::SCB_M8_LVDS ? 16'h200a : pll ? 16'h2006 : 16'h2002);
		push(`SCB_REG_LOGIC_EN, 16'h0001);
		push(`SCB_REG_IMG_CORE, 16'h085a);
		push(`SCB_REG_OUT_WIDTH, b8 ? 16'h2000 : 16'h0000);
		push(`SCB_REG_BIAS_CP, 16'h288b);
		push(`SCB_REG_BIAS_FE, 16'h53c6);
		push(`SCB_REG_BIAS_MUX, 16'h0344);
		push(`SCB_REG_BIAS_SER, 16'h0085);
		push(`SCB_REG_RSV_A, 16'h4888);
		push(`SCB_REG_RSV_B, 16'h86a1);
		push(`SCB_REG_BLACK, 16'h460f);
		push(`SCB_REG_EXP_A, 16'h00f5);
		push(`SCB_REG_EXP_B, 16'h00fd);
		push(`SCB_REG_EXP_C, 16'h0144);
		push(`SCB_REG_SEQ_A, 16'h160b);
		push(`SCB_REG_SEQ_B, 16'h3e13);
		push(`SCB_REG_SEQ_C, 16'h0386);
		push(`SCB_REG_SEQ_D, 16'h0bf1);
		push(`SCB_REG_SEQ_E, 16'h0bc3);
		chk(log_q.size(), exp_q.size());
		for (int k = 0; k < exp_q.size() && k < log_q.size(); k++)
			chk({7'h0, log_q[k]}, {7'h0, exp_q[k]});
		chk(lock_reads > 0, pll);
		chk(outs, {pll, m == scb_pkg::SCB_MPAR, !pll && m != scb_pkg::SCB_MPAR,
			1'b1, 1'b1, b8});
	endtask
	initial begin
		repeat (4) @(posedge clk);
		for (int i = 0; i < 6; i++)
			run_mode(scb_pkg::scb_mode_t'(i < 5 ? i : 4), i[0]);
		end_of_test();
	end
endmodule
`default_nettype wire
